// >>> hw/lssf_pkg.sv
// constants of the serial status flag block
// assumes a byte-wide register port and event strobes from the receiver
// Functional notes
// - set tx empty flag, bit 7, when holding buffer moves to shifter
// - request serial interrupt while tx empty and its enable are set
// - set tx done flag, bit 6, after a data character; interrupt if enabled
// - preamble or break transmission leaves tx done flag untouched
// - status read then data write clears tx empty and tx done
// - set rx full flag, bit 5, on data register load; interrupt if enabled
// - set idle flag, bit 4, on idle line; interrupt if enabled
// - idle flag sets again only after rx full flag was set meanwhile
// - header error flag, bit 3, on sync corruption, header timeout or overrun
// - header error clears only after sync lock released; interrupts with rx enable
// - outside headers the header error flag reports receive overrun
// - noise flag, bit 2, works in master mode; meaningless in slave mode
// - slave framing error, bit 1, needs stop dominant and another bit recessive
// - slave break never sets framing error; header detect flag does instead while header wake select, mode bit 2, is clear
// - parity error, bit 0, set on parity fault when checking enabled
// - status read then data read clears rx full, idle, parity error
// - muted receiver drops non-break framing errors without flagging
package lssf_pkg;
    localparam logic [2:0] ADR_STATUS = 3'h0;
    localparam logic [2:0] ADR_DATA = 3'h1;
    localparam logic [2:0] ADR_CTRL1 = 3'h2;
    localparam logic [2:0] ADR_CTRL2 = 3'h3;
    localparam logic [2:0] ADR_MODE = 3'h4;
    localparam logic [2:0] ADR_IRQ_ST = 3'h5;
    localparam logic [2:0] ADR_IRQ_MSK = 3'h6;
    localparam int B_TXE = 7;
    localparam int B_TXD = 6;
    localparam int B_RXF = 5;
    localparam int B_IDLE = 4;
    localparam int B_HDR = 3;
    localparam int B_NOISE = 2;
    localparam int B_FRAME = 1;
    localparam int B_PAR = 0;
    localparam int B_TX_IE = 7;
    localparam int B_TXD_IE = 6;
    localparam int B_RX_IE = 5;
    localparam int B_IDLE_IE = 4;
    localparam int B_PCE = 2;
    localparam int B_PIE = 0;
    localparam int B_LIN_EN = 0;
    localparam int B_SLAVE = 1;
    localparam int B_HWS = 2;
    localparam int B_HDF = 7;
    localparam logic [7:0] STATUS_RST = 8'hC0;
    localparam logic [7:0] TX_CLR_MASK = 8'hC0;
    localparam logic [7:0] RX_CLR_MASK = 8'h3F;
    localparam logic [7:0] CTRL1_MASK = 8'hFD;
    localparam logic [7:0] MODE_WR_MASK = 8'h07;
    localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// >>> hw/lssf_top.sv
// status flags, flag interrupts and clear sequences of a LIN serial port
// assumes the shifters, baud logic and header detector deliver one-cycle event strobes
`timescale 1ns/10ps
`default_nettype none
module lssf_top (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic TX_LOAD,
    input wire logic TX_DONE_DATA,
    input wire logic TX_DONE_SPECIAL,
    input wire logic RX_LOAD,
    input wire logic [7:0] RX_DATA,
    input wire logic IDLE_DET,
    input wire logic SYNC_CORRUPT,
    input wire logic HDR_TIMEOUT,
    input wire logic OVERRUN,
    input wire logic SYNC_LOCK,
    input wire logic NOISE_DET,
    input wire logic CHAR_DONE,
    input wire logic STOP_BIT,
    input wire logic ONE_SEEN,
    input wire logic BREAK_DET,
    input wire logic PARITY_ERR,
    input wire logic MUTED,
    output logic [7:0] TX_DATA,
    output logic TX_WRITE,
    output logic LIN_EN,
    output logic SLAVE_SEL,
    output logic HDR_WAKE_SEL,
    output logic SER_IRQ,
    output logic IRQ
);
    typedef struct packed {
        logic [7:0] st;
        logic [7:0] arm;
        logic idle_blk;
        logic [7:0] cr1;
        logic [7:0] cr2;
        logic [7:0] mode;
        logic [7:0] irq_st;
        logic [7:0] irq_msk;
        logic [7:0] rx_data;
        logic [7:0] tx_data;
        logic tx_wr;
        logic [7:0] rdata;
    } lssf_state_t;

    lssf_state_t s_r;
    lssf_state_t s_nxt;
    logic [7:0] ev;
    logic [7:0] clr;
    logic slave;
    logic st_rd;
    logic dt_rd;
    logic dt_wr;

    // one strobe qualified by one register index
    function automatic logic acc(input logic strobe, input logic [2:0] a, input logic [2:0] idx);
        return strobe && a == idx;
    endfunction

    always_comb begin
        slave = s_r.mode[lssf_pkg::B_LIN_EN] & s_r.mode[lssf_pkg::B_SLAVE];
        st_rd = acc(RD, ADDR, lssf_pkg::ADR_STATUS);
        dt_rd = acc(RD, ADDR, lssf_pkg::ADR_DATA);
        dt_wr = acc(WR, ADDR, lssf_pkg::ADR_DATA);
        ev = lssf_pkg::ZERO8;
        ev[lssf_pkg::B_TXE] = TX_LOAD;
        ev[lssf_pkg::B_TXD] = TX_DONE_DATA;
        ev[lssf_pkg::B_RXF] = RX_LOAD;
        ev[lssf_pkg::B_IDLE] = IDLE_DET & ~s_r.idle_blk;
        // overrun flags here both inside and outside a header
        ev[lssf_pkg::B_HDR] = SYNC_CORRUPT | HDR_TIMEOUT | OVERRUN;
        ev[lssf_pkg::B_NOISE] = NOISE_DET & ~slave;
        // slave: real framing fault only; muted: non-break faults dropped
        ev[lssf_pkg::B_FRAME] = CHAR_DONE & ~STOP_BIT
            & ~(slave & (BREAK_DET | ~ONE_SEEN))
            & ~(MUTED & ~BREAK_DET);
        ev[lssf_pkg::B_PAR] = PARITY_ERR & s_r.cr1[lssf_pkg::B_PCE];

        clr = lssf_pkg::ZERO8;
        if (dt_wr) begin
            clr = s_r.arm & lssf_pkg::TX_CLR_MASK;
        end else if (dt_rd) begin
            clr = s_r.arm & lssf_pkg::RX_CLR_MASK;
            // header error held while the sync state is locked
            if (SYNC_LOCK) begin
                clr[lssf_pkg::B_HDR] = 1'b0;
            end
        end

        s_nxt = s_r;
        s_nxt.tx_wr = 1'b0;
        // set wins over a clear in the same cycle
        s_nxt.st = (s_r.st & ~clr) | ev;
        if (st_rd) begin
            s_nxt.arm = s_r.st;
        end else if (dt_wr || dt_rd) begin
            s_nxt.arm = s_r.arm & ~clr;
        end
        if (RX_LOAD) begin
            s_nxt.rx_data = RX_DATA;
        end
        // a load in the same cycle as the idle set is not in between
        if (ev[lssf_pkg::B_IDLE]) begin
            s_nxt.idle_blk = 1'b1;
        end else if (RX_LOAD) begin
            s_nxt.idle_blk = 1'b0;
        end
        if (dt_wr) begin
            s_nxt.tx_data = WDATA;
            s_nxt.tx_wr = 1'b1;
        end
        if (acc(WR, ADDR, lssf_pkg::ADR_CTRL1)) begin
            s_nxt.cr1 = WDATA & lssf_pkg::CTRL1_MASK;
        end
        if (acc(WR, ADDR, lssf_pkg::ADR_CTRL2)) begin
            s_nxt.cr2 = WDATA;
        end
        if (acc(WR, ADDR, lssf_pkg::ADR_MODE)) begin
            s_nxt.mode = (s_r.mode & ~lssf_pkg::MODE_WR_MASK) | (WDATA & lssf_pkg::MODE_WR_MASK);
        end
        // header detect acts as the slave break flag, cleared like framing error
        if (dt_rd && s_r.arm[lssf_pkg::B_FRAME]) begin
            s_nxt.mode[lssf_pkg::B_HDF] = 1'b0;
        end
        if (slave && BREAK_DET && CHAR_DONE && !s_r.mode[lssf_pkg::B_HWS]) begin
            s_nxt.mode[lssf_pkg::B_HDF] = 1'b1;
        end
        if (acc(WR, ADDR, lssf_pkg::ADR_IRQ_MSK)) begin
            s_nxt.irq_msk = WDATA;
        end
        if (acc(RD, ADDR, lssf_pkg::ADR_IRQ_ST)) begin
            s_nxt.irq_st = ev;
        end else begin
            s_nxt.irq_st = s_r.irq_st | ev;
        end
        case (ADDR)
            lssf_pkg::ADR_STATUS: s_nxt.rdata = s_r.st;
            lssf_pkg::ADR_DATA: s_nxt.rdata = s_r.rx_data;
            lssf_pkg::ADR_CTRL1: s_nxt.rdata = s_r.cr1;
            lssf_pkg::ADR_CTRL2: s_nxt.rdata = s_r.cr2;
            lssf_pkg::ADR_MODE: s_nxt.rdata = s_r.mode;
            lssf_pkg::ADR_IRQ_ST: s_nxt.rdata = s_r.irq_st;
            lssf_pkg::ADR_IRQ_MSK: s_nxt.rdata = s_r.irq_msk;
            default: s_nxt.rdata = lssf_pkg::ZERO8;
        endcase
        if (!RD) begin
            s_nxt.rdata = lssf_pkg::ZERO8;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            s_r <= '0;
            s_r.st <= lssf_pkg::STATUS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RDATA = s_r.rdata;
    assign TX_DATA = s_r.tx_data;
    assign TX_WRITE = s_r.tx_wr;
    assign LIN_EN = s_r.mode[lssf_pkg::B_LIN_EN];
    assign SLAVE_SEL = s_r.mode[lssf_pkg::B_SLAVE];
    assign HDR_WAKE_SEL = s_r.mode[lssf_pkg::B_HWS];
    // header error shares the receive enable
    assign SER_IRQ = (s_r.st[lssf_pkg::B_TXE] & s_r.cr2[lssf_pkg::B_TX_IE])
        | (s_r.st[lssf_pkg::B_TXD] & s_r.cr2[lssf_pkg::B_TXD_IE])
        | ((s_r.st[lssf_pkg::B_RXF] | s_r.st[lssf_pkg::B_HDR]) & s_r.cr2[lssf_pkg::B_RX_IE])
        | (s_r.st[lssf_pkg::B_IDLE] & s_r.cr2[lssf_pkg::B_IDLE_IE])
        | (s_r.st[lssf_pkg::B_PAR] & s_r.cr1[lssf_pkg::B_PIE]);
    assign IRQ = |(s_r.irq_st & s_r.irq_msk);

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    a_txe_set: assert property (TX_LOAD |=> s_r.st[7]) else $error("tx empty not set");
    a_tx_irq: assert property (s_r.st[7] && s_r.cr2[7] |-> SER_IRQ) else $error("tx irq missing");
    a_txd_set: assert property (TX_DONE_DATA |=> s_r.st[6]) else $error("tx done not set");
    a_txd_special: assert property (TX_DONE_SPECIAL && !TX_DONE_DATA && !dt_wr
        |=> s_r.st[6] == $past(s_r.st[6])) else $error("tx done moved on special");
    a_tx_clear_seq: assert property ((st_rd && s_r.st[7]) ##1 (dt_wr && !TX_LOAD)
        |=> !s_r.st[7]) else $error("tx empty not cleared");
    a_rxf_set: assert property (RX_LOAD |=> s_r.st[5] && s_r.rx_data == $past(RX_DATA))
        else $error("rx full not set");
    a_idle_once: assert property (s_r.idle_blk && !s_r.st[4] && !RX_LOAD |=> !s_r.st[4])
        else $error("idle set twice");
    a_hdr_locked: assert property (SYNC_LOCK && s_r.st[3] |=> s_r.st[3])
        else $error("header error cleared in lock");
    a_frame_break: assert property (slave && BREAK_DET && !s_r.st[1] |=> !s_r.st[1])
        else $error("framing set on break");
    a_par_gate: assert property (!s_r.cr1[2] && !s_r.st[0] |=> !s_r.st[0])
        else $error("parity set without check");
    a_late_flag: assert property (st_rd && !s_r.st[5] ##1 (RX_LOAD && !dt_rd) ##1 dt_rd
        |=> s_r.st[5]) else $error("late flag cleared");
    a_status_ro: assert property (WR && ADDR == 3'h0 && ev == 8'h00 && !dt_rd
        |=> s_r.st == $past(s_r.st)) else $error("status written");

    // transmit side
    a_txd_clear: assert property (
        (st_rd && s_r.st[6]) ##1 (dt_wr && !TX_DONE_DATA)
        |=> !s_r.st[6])
        else $error("tx done not cleared");

    a_txd_irq: assert property (
        s_r.st[6] && s_r.cr2[6]
        |-> SER_IRQ)
        else $error("tx done irq missing");

    a_irq_quiet: assert property (
        !s_r.st[7] && !s_r.st[6] && !s_r.st[5] && !s_r.st[4] && !s_r.st[3] && !s_r.st[0]
        |-> !SER_IRQ)
        else $error("serial irq without flag");

    a_txwr_pulse: assert property (
        dt_wr
        |=> TX_WRITE && TX_DATA == $past(WDATA))
        else $error("tx byte not handed on");

    // receive side
    a_rxf_irq: assert property (
        s_r.st[5] && s_r.cr2[5]
        |-> SER_IRQ)
        else $error("rx full irq missing");

    a_idle_set: assert property (
        IDLE_DET && !s_r.idle_blk
        |=> s_r.st[4])
        else $error("idle not set");

    a_idle_irq: assert property (
        s_r.st[4] && s_r.cr2[4]
        |-> SER_IRQ)
        else $error("idle irq missing");

    a_idle_block: assert property (
        IDLE_DET && !RX_LOAD
        |=> s_r.idle_blk)
        else $error("idle not blocked");

    a_rx_unblock: assert property (
        RX_LOAD && !IDLE_DET
        |=> !s_r.idle_blk)
        else $error("idle not released by load");

    a_rx_clear: assert property (
        (st_rd && s_r.st[5]) ##1 (dt_rd && !RX_LOAD)
        |=> !s_r.st[5])
        else $error("rx full not cleared");

    a_idle_clear: assert property (
        (st_rd && s_r.st[4]) ##1 (dt_rd && !IDLE_DET)
        |=> !s_r.st[4])
        else $error("idle not cleared");

    a_par_clear: assert property (
        (st_rd && s_r.st[0]) ##1 (dt_rd && !PARITY_ERR)
        |=> !s_r.st[0])
        else $error("parity not cleared");

    a_rdata_idle: assert property (
        !RD
        |=> RDATA == 8'h00)
        else $error("read data outside read");

    // header errors
    a_hdr_sync: assert property (
        SYNC_CORRUPT
        |=> s_r.st[3])
        else $error("sync fault not flagged");

    a_hdr_timeout: assert property (
        HDR_TIMEOUT
        |=> s_r.st[3])
        else $error("header timeout not flagged");

    a_overrun_flag: assert property (
        OVERRUN
        |=> s_r.st[3])
        else $error("overrun not flagged");

    a_hdr_irq: assert property (
        s_r.st[3] && s_r.cr2[5]
        |-> SER_IRQ)
        else $error("header irq missing");

    a_hdr_clear: assert property (
        (st_rd && s_r.st[3]) ##1 (dt_rd && !SYNC_LOCK && !SYNC_CORRUPT && !HDR_TIMEOUT && !OVERRUN)
        |=> !s_r.st[3])
        else $error("header error not cleared");

    // noise, framing, parity
    a_noise_master: assert property (
        NOISE_DET && !slave
        |=> s_r.st[2])
        else $error("noise not set in master");

    a_noise_slave: assert property (
        slave && !s_r.st[2]
        |=> !s_r.st[2])
        else $error("noise set in slave");

    a_frame_set: assert property (
        CHAR_DONE && !STOP_BIT && ONE_SEEN && !BREAK_DET && !MUTED
        |=> s_r.st[1])
        else $error("framing not set");

    a_frame_no_one: assert property (
        slave && CHAR_DONE && !ONE_SEEN && !s_r.st[1]
        |=> !s_r.st[1])
        else $error("framing set without recessive bit");

    a_hdf_break: assert property (
        slave && BREAK_DET && CHAR_DONE && !s_r.mode[2]
        |=> s_r.mode[7])
        else $error("break not flagged as header");

    a_frame_clear: assert property (
        (st_rd && s_r.st[1]) ##1 (dt_rd && !CHAR_DONE)
        |=> !s_r.st[1])
        else $error("framing not cleared");

    a_par_set: assert property (
        PARITY_ERR && s_r.cr1[2]
        |=> s_r.st[0])
        else $error("parity not set");

    a_par_irq: assert property (
        s_r.st[0] && s_r.cr1[0]
        |-> SER_IRQ)
        else $error("parity irq missing");

    a_muted_drop: assert property (
        MUTED && !BREAK_DET && !s_r.st[1]
        |=> !s_r.st[1])
        else $error("muted framing flagged");

    // clear sequence arming
    a_arm_load: assert property (
        st_rd
        |=> s_r.arm == $past(s_r.st))
        else $error("arm not loaded");

    a_unarmed_kept: assert property (
        dt_rd && !s_r.arm[5] && s_r.st[5]
        |=> s_r.st[5])
        else $error("unarmed flag cleared");

    c_tx_seq: cover property (st_rd ##1 dt_wr ##1 !s_r.st[7]);
    c_rx_seq: cover property (RX_LOAD ##1 st_rd ##1 dt_rd ##1 !s_r.st[5]);
    c_hdr_err: cover property (SYNC_CORRUPT ##1 s_r.st[3]);
    c_irq: cover property (IRQ && SER_IRQ);
endmodule
`default_nettype wire

// >>> tb/lssf_line_model.sv
// far-side model: line events as the shifters and header logic present them
// assumes the bench requests events one cycle ahead, one request per call
`timescale 1ns/10ps
`default_nettype none
module lssf_line_model (
    input wire logic clk,
    input wire logic [13:0] req,
    output logic [13:0] ev = 14'h0000
);
    // every event is a single-cycle strobe, levels ride with it
    always @(posedge clk) begin
        ev <= req;
    end
endmodule
`default_nettype wire

// >>> tb/tb_lin_serial_status_flags.sv
// self-checking bench of the serial status flag block
// assumes the register port answers a read in the next cycle only
`timescale 1ns/10ps
`default_nettype none
module tb_lin_serial_status_flags;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [13:0] req = 14'h0000;
    logic sync_lock = 1'b0;
    logic muted = 1'b0;
    logic [13:0] ev;
    logic [7:0] rdata, tx_data;
    logic tx_write, lin_en, slave_sel, hdr_wake_sel, ser_irq, irq;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    always #20 mclk = ~mclk;
    lssf_line_model lssf_line_model_i (.clk(mclk), .req(req), .ev(ev));
    lssf_top lssf_top_i (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .TX_LOAD(ev[0]), .TX_DONE_DATA(ev[1]), .TX_DONE_SPECIAL(ev[2]), .RX_LOAD(ev[3]), .RX_DATA(8'h3C),
        .IDLE_DET(ev[4]), .SYNC_CORRUPT(ev[5]), .HDR_TIMEOUT(ev[6]), .OVERRUN(ev[7]), .SYNC_LOCK(sync_lock),
        .NOISE_DET(ev[8]), .CHAR_DONE(ev[9]), .STOP_BIT(ev[10]), .ONE_SEEN(ev[11]), .BREAK_DET(ev[12]),
        .PARITY_ERR(ev[13]), .MUTED(muted), .TX_DATA(tx_data), .TX_WRITE(tx_write), .LIN_EN(lin_en),
        .SLAVE_SEL(slave_sel), .HDR_WAKE_SEL(hdr_wake_sel), .SER_IRQ(ser_irq), .IRQ(irq));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic wrt(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask
    // request, model strobe, flag update, then settle
    task automatic evt(input logic [13:0] v);
        @(posedge mclk);
        req <= v;
        @(posedge mclk);
        req <= 14'h0000;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic t_reset();
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        chk({6'h00, ser_irq, irq}, 8'h00);
        wrt(lssf_pkg::ADR_STATUS, 8'h00);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
    endtask
    task automatic t_tx();
        wrt(lssf_pkg::ADR_DATA, 8'h5A);
        chk(tx_data, 8'h5A);
        chk({7'h00, tx_write}, 8'h01);
        rdc(lssf_pkg::ADR_STATUS, 8'h00);
        evt(14'h0004);
        rdc(lssf_pkg::ADR_STATUS, 8'h00);
        evt(14'h0001);
        rdc(lssf_pkg::ADR_STATUS, 8'h80);
        wrt(lssf_pkg::ADR_CTRL2, 8'h80);
        chk(ser_irq, 8'h01);
        evt(14'h0002);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        wrt(lssf_pkg::ADR_CTRL2, 8'h40);
        chk(ser_irq, 8'h01);
        wrt(lssf_pkg::ADR_CTRL2, 8'h00);
    endtask
    task automatic t_rx();
        evt(14'h0018);
        rdc(lssf_pkg::ADR_STATUS, 8'hF0);
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        evt(14'h0010);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        evt(14'h0008);
        evt(14'h0010);
        rdc(lssf_pkg::ADR_STATUS, 8'hF0);
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
    endtask
    task automatic t_par();
        evt(14'h2000);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        wrt(lssf_pkg::ADR_CTRL1, 8'h05);
        evt(14'h0000);
        evt(14'h2000);
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
        rdc(lssf_pkg::ADR_STATUS, 8'hC1);
        chk(ser_irq, 8'h01);
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        wrt(lssf_pkg::ADR_CTRL1, 8'h00);
    endtask
    task automatic t_hdr();
        wrt(lssf_pkg::ADR_CTRL2, 8'h20);
        for (int k = 5; k < 8; k++) begin
            evt(14'h0001 << k);
            rdc(lssf_pkg::ADR_STATUS, 8'hC8);
            chk(ser_irq, 8'h01);
            rdc(lssf_pkg::ADR_DATA, 8'h3C);
            chk(ser_irq, 8'h00);
        end
        sync_lock <= 1'b1;
        evt(14'h0020);
        rdc(lssf_pkg::ADR_STATUS, 8'hC8);
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
        rdc(lssf_pkg::ADR_STATUS, 8'hC8);
        sync_lock <= 1'b0;
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        wrt(lssf_pkg::ADR_CTRL2, 8'h00);
    endtask
    task automatic t_frame();
        wrt(lssf_pkg::ADR_MODE, 8'h01);
        evt(14'h0100);
        rdc(lssf_pkg::ADR_STATUS, 8'hC4);
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
        wrt(lssf_pkg::ADR_MODE, 8'h03);
        chk({5'h00, hdr_wake_sel, slave_sel, lin_en}, 8'h03);
        evt(14'h0200);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        evt(14'h0A00);
        rdc(lssf_pkg::ADR_STATUS, 8'hC2);
        rdc(lssf_pkg::ADR_DATA, 8'h3C);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        evt(14'h1A00);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        rdc(lssf_pkg::ADR_MODE, 8'h83);
        muted <= 1'b1;
        evt(14'h0A00);
        rdc(lssf_pkg::ADR_STATUS, 8'hC0);
        muted <= 1'b0;
    endtask
    task automatic t_irq();
        wrt(lssf_pkg::ADR_IRQ_MSK, 8'h20);
        chk(irq, 8'h01);
        rdc(lssf_pkg::ADR_IRQ_ST, 8'hFF);
        chk(irq, 8'h00);
        evt(14'h0008);
        chk(irq, 8'h01);
        rdc(lssf_pkg::ADR_IRQ_ST, 8'h20);
        rdc(lssf_pkg::ADR_IRQ_MSK, 8'h20);
        chk(irq, 8'h00);
        rdc(3'h7, 8'h00);
    endtask
    // generous ceiling, the sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_par();
        t_hdr();
        t_frame();
        t_irq();
        complete_run();
    end
endmodule
`default_nettype wire
